// file: core/crc_fifo_engine.sv
// programmable crc engine with width-dependent input fifo and apb register slave
// Function
// - polynomial order up to 32, five-bit length
// - set tap bit enables xor stage
// - highest term tap bit has no effect
// - direction bit: msb first or lsb first
// - direction affects input only, result normal
// - element width 1..32, field holds width-1
// - readable five-bit count of queued elements
// - depth 16, 8 or 4 by width
// - narrow widths push on low byte write
// - mid widths push on low halfword write
// - wide widths: low first, high pushes
// - writes while full are discarded
// - go and nonzero count move entries
// - full at depth, clears on decrement
// - empty flag set when count zero
// - clearing go pauses, setting resumes
// - enable low flushes fifo, count zero
// - two cycles to load, width+1 to shift
// - bits above width are ignored
// - width change while idle loses nothing
// - length is field plus one, feedback there
// - shift result register loads and reads engine
//
// Register access over APB and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module crc_fifo_engine
    import crc_fifo_pkg::*;
#(
    parameter int SLOTS = FIFO_SLOTS
) (
    input  wire logic              sys_clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr
);

    localparam int PTR_W = $clog2(SLOTS);

    // ***************************************************************
    // helpers
    // ***************************************************************
    function automatic logic [31:0] byte_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic [4:0] depth_of(input logic [4:0] width_field);
        logic [4:0] d;
        if (width_field <= WIDTH_NARROW_MAX) begin
            d = DEPTH_NARROW;
        end else if (width_field <= WIDTH_MID_MAX) begin
            d = DEPTH_MID;
        end else begin
            d = DEPTH_WIDE;
        end
        return d;
    endfunction

    // ***************************************************************
    // state
    // ***************************************************************
    logic              module_enable_bit_q;
    logic              go_bit_q;
    logic              lsb_first_sel_q;
    logic [4:0]        elem_width_field_q;
    logic [4:0]        poly_length_field_q;
    logic [31:0]       poly_tap_regs_q;
    logic [15:0]       low_hold_q;
    logic [31:0]       fifo_mem [SLOTS];
    logic [PTR_W-1:0]  wr_ptr_q;
    logic [PTR_W-1:0]  rd_ptr_q;
    logic [4:0]        fifo_count_q;
    logic [4:0]        fifo_count_d;
    logic [31:0]       shift_buf_q;
    logic [31:0]       shift_result_regs_q;
    logic [31:0]       crc_d;
    logic [4:0]        bit_cnt_q;
    logic [4:0]        bit_cnt_d;
    xfer_state_e       state_q;
    xfer_state_e       state_d;
    logic [31:0]       prdata_q;
    logic              pready_q;
    logic              pslverr_q;

    // ***************************************************************
    // apb decode
    // ***************************************************************
    wire setup_phase  = psel & ~penable;
    wire access_phase = psel & penable & pready_q;
    wire wr_access    = access_phase & pwrite;
    wire hit_ctrl_a   = (paddr == CTRL_A_OFS);
    wire hit_ctrl_b   = (paddr == CTRL_B_OFS);
    wire hit_taps     = (paddr == POLY_TAP_OFS);
    wire hit_low      = (paddr == DATA_LOW_OFS);
    wire hit_high     = (paddr == DATA_HIGH_OFS);
    wire hit_result   = (paddr == SHIFT_RES_OFS);
    wire mapped       = hit_ctrl_a | hit_ctrl_b | hit_taps | hit_low | hit_high | hit_result;

    // ***************************************************************
    // fifo flags and push qualification
    // ***************************************************************
    wire [4:0] cur_depth       = depth_of(elem_width_field_q);
    wire       fifo_full_flag  = (fifo_count_q >= cur_depth);
    wire       fifo_empty_flag = (fifo_count_q == 5'h00);
    wire       width_narrow    = (elem_width_field_q <= WIDTH_NARROW_MAX);
    wire       width_wide      = (elem_width_field_q > WIDTH_MID_MAX);
    wire       width_mid       = ~width_narrow & ~width_wide;

    wire push_narrow = wr_access & hit_low & width_narrow & pstrb[0];
    wire push_mid    = wr_access & hit_low & width_mid & (&pstrb[1:0]);
    wire push_wide   = wr_access & hit_high & width_wide & (&pstrb[1:0]);
    wire push_req    = push_narrow | push_mid | push_wide;
    // a write into a full fifo is dropped, and so is any write while disabled
    wire push        = push_req & ~fifo_full_flag & module_enable_bit_q;
    wire [31:0] push_data = width_wide ? {pwdata[15:0], low_hold_q} : pwdata;

    // ***************************************************************
    // sequencer and shift engine datapath
    // ***************************************************************
    wire run_ok      = module_enable_bit_q & go_bit_q;
    wire start_ok    = run_ok & ~fifo_empty_flag;
    wire pop         = (state_q == ST_XFER) & start_ok;
    wire advance     = (state_q == ST_SHIFT) & run_ok;
    wire last_bit    = (bit_cnt_q == elem_width_field_q);
    wire res_wr      = wr_access & hit_result;
    // only width+1 bits are ever picked, so upper element bits never matter
    wire [4:0] bit_idx = lsb_first_sel_q ? bit_cnt_q
                                         : 5'(elem_width_field_q - bit_cnt_q);
    wire       din       = shift_buf_q[bit_idx];
    wire [31:0] len_mask = LEN_MASK_ALL >> (FIELD_MAX - poly_length_field_q);
    wire        feedback = shift_result_regs_q[poly_length_field_q];
    wire [31:0] eff_taps = poly_tap_regs_q | CONST_TERM;
    wire [31:0] shifted  = {shift_result_regs_q[30:0], din};
    // the mask drops anything at or above the top term, so its tap bit is inert
    wire [31:0] crc_step = (shifted ^ (feedback ? eff_taps : 32'h0)) & len_mask;
    wire [31:0] res_wr_val = byte_merge(shift_result_regs_q, pwdata, pstrb);
    wire [31:0] low_merge  = byte_merge({16'h0, low_hold_q}, pwdata, pstrb);

    always_comb begin
        state_d   = state_q;
        bit_cnt_d = bit_cnt_q;
        crc_d     = shift_result_regs_q;
        case (state_q)
            ST_IDLE: begin
                if (start_ok) begin
                    state_d = ST_XFER;
                end
            end
            ST_XFER: begin
                if (!module_enable_bit_q || fifo_empty_flag) begin
                    state_d = ST_IDLE;
                end else if (go_bit_q) begin
                    state_d   = ST_SHIFT;
                    bit_cnt_d = 5'h00;
                end
            end
            ST_SHIFT: begin
                if (advance) begin
                    crc_d     = crc_step;
                    bit_cnt_d = 5'(bit_cnt_q + 5'h01);
                    if (last_bit) begin
                        state_d = ST_IDLE;
                    end
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
        // a direct load of the engine also discards the element in flight
        if (res_wr) begin
            crc_d   = res_wr_val;
            state_d = ST_IDLE;
        end
    end

    // ***************************************************************
    // fifo occupancy
    // ***************************************************************
    always_comb begin
        if (!module_enable_bit_q) begin
            fifo_count_d = 5'h00;
        end else begin
            case ({push, pop})
                2'b10:   fifo_count_d = 5'(fifo_count_q + 5'h01);
                2'b01:   fifo_count_d = 5'(fifo_count_q - 5'h01);
                default: fifo_count_d = fifo_count_q;
            endcase
        end
    end

    // ***************************************************************
    // read mux
    // ***************************************************************
    wire [31:0] rd_ctrl_a = {16'h0, module_enable_bit_q, 2'b00, fifo_count_q,
                             fifo_full_flag, fifo_empty_flag, (state_q != ST_IDLE),
                             go_bit_q, lsb_first_sel_q, 3'b000};
    wire [31:0] rd_ctrl_b = {19'h0, elem_width_field_q, 3'b000, poly_length_field_q};
    // the data input registers are a write-only port into the fifo
    wire [31:0] rd_mux = hit_ctrl_a ? rd_ctrl_a :
                         hit_ctrl_b ? rd_ctrl_b :
                         hit_taps   ? poly_tap_regs_q :
                         hit_result ? shift_result_regs_q : 32'h0;
    wire [31:0] wr_ctrl_a = byte_merge(rd_ctrl_a, pwdata, pstrb);
    wire [31:0] wr_ctrl_b = byte_merge(rd_ctrl_b, pwdata, pstrb);
    wire [31:0] wr_taps   = byte_merge(poly_tap_regs_q, pwdata, pstrb) & TAP_WR_MASK;

    // ***************************************************************
    // apb slave: zero wait state access, answer in the access cycle
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= setup_phase;
            pslverr_q <= setup_phase & ~mapped;
            prdata_q  <= (setup_phase & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            module_enable_bit_q <= 1'b0;
            go_bit_q            <= 1'b0;
            lsb_first_sel_q     <= 1'b0;
            elem_width_field_q  <= FIELD_RST;
            poly_length_field_q <= FIELD_RST;
            poly_tap_regs_q     <= TAPS_RST;
        end else begin
            if (wr_access && hit_ctrl_a) begin
                module_enable_bit_q <= wr_ctrl_a[ENABLE_BIT];
                go_bit_q            <= wr_ctrl_a[GO_BIT];
                lsb_first_sel_q     <= wr_ctrl_a[LSB_FIRST_BIT];
            end
            if (wr_access && hit_ctrl_b) begin
                elem_width_field_q  <= wr_ctrl_b[WIDTH_LSB +: FIELD_W];
                poly_length_field_q <= wr_ctrl_b[POLY_LENGTH_FIELD_LSB +: FIELD_W];
            end
            if (wr_access && hit_taps) begin
                poly_tap_regs_q <= wr_taps;
            end
        end
    end

    // ***************************************************************
    // fifo storage and pointers
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (push) begin
            fifo_mem[wr_ptr_q] <= push_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || !module_enable_bit_q) begin
            wr_ptr_q     <= '0;
            rd_ptr_q     <= '0;
            fifo_count_q <= 5'h00;
            low_hold_q   <= 16'h0;
        end else begin
            fifo_count_q <= fifo_count_d;
            if (push) begin
                wr_ptr_q <= PTR_W'(wr_ptr_q + 1'b1);
            end
            if (pop) begin
                rd_ptr_q <= PTR_W'(rd_ptr_q + 1'b1);
            end
            if (wr_access && hit_low) begin
                low_hold_q <= low_merge[15:0];
            end
        end
    end

    // ***************************************************************
    // engine registers
    // ***************************************************************
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q             <= ST_IDLE;
            bit_cnt_q           <= 5'h00;
            shift_buf_q         <= 32'h0;
            shift_result_regs_q <= CRC_RST;
        end else begin
            state_q             <= state_d;
            bit_cnt_q           <= bit_cnt_d;
            shift_result_regs_q <= crc_d;
            if (pop) begin
                shift_buf_q <= fifo_mem[rd_ptr_q];
            end
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ***************************************************************
    // checks
    // ***************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence s_start_seen;
        (state_q == ST_IDLE) && start_ok && !res_wr;
    endsequence

    sequence s_load_taken;
        pop && !res_wr;
    endsequence

    a_count_flush: assert property (!module_enable_bit_q |=> fifo_count_q == 5'h00)
        else $error("fifo count not cleared while disabled");

    a_full_discard: assert property (push_req && fifo_full_flag && !pop && module_enable_bit_q
                                     |=> fifo_count_q == $past(fifo_count_q))
        else $error("write into full fifo changed the count");

    a_push_count: assert property (push && !pop |=> fifo_count_q == 5'($past(fifo_count_q) + 5'h01))
        else $error("push did not raise the count by one");

    a_pop_count: assert property (pop && !push |=> fifo_count_q == 5'($past(fifo_count_q) - 5'h01))
        else $error("move to buffer did not lower the count by one");

    a_start_two_cycles: assert property (s_start_seen ##1 s_load_taken |=> state_q == ST_SHIFT)
        else $error("shifting did not begin two cycles after start");

    a_shift_end: assert property (advance && last_bit && !res_wr |=> state_q == ST_IDLE
                                  && bit_cnt_q == 5'($past(elem_width_field_q) + 5'h01))
        else $error("element shift did not take width plus one cycles");

    a_pause_hold: assert property ((state_q == ST_SHIFT) && !go_bit_q && !res_wr
                                   |=> $stable(shift_result_regs_q) && $stable(bit_cnt_q))
        else $error("engine moved while paused");

    a_top_masked: assert property (advance && !res_wr |=> (shift_result_regs_q & ~$past(len_mask)) == 32'h0)
        else $error("engine bits above polynomial length are set");

    a_data_reads_zero: assert property (setup_phase && !pwrite && (hit_low || hit_high) |=> prdata == 32'h0)
        else $error("data input register did not read zero");

    a_result_load: assert property (res_wr |=> shift_result_regs_q == $past(res_wr_val)
                                    && state_q == ST_IDLE)
        else $error("shift result write did not load the engine");

    a_empty_read: assert property (setup_phase && !pwrite && hit_ctrl_a
                                   |=> prdata[EMPTY_BIT] == ($past(fifo_count_q) == 5'h00))
        else $error("empty flag disagrees with count");

endmodule

`default_nettype wire

// file: core/crc_fifo_pkg.sv
// constants, register map and state codes of the programmable crc fifo engine
package crc_fifo_pkg;

    // ***************************************************************
    // register map (byte addresses, one 32-bit word each)
    // ***************************************************************
    localparam int         ADDR_W        = 8;
    localparam logic [7:0] CTRL_A_OFS    = 8'h00;
    localparam logic [7:0] CTRL_B_OFS    = 8'h04;
    localparam logic [7:0] POLY_TAP_OFS  = 8'h08;
    localparam logic [7:0] DATA_LOW_OFS  = 8'h0c;
    localparam logic [7:0] DATA_HIGH_OFS = 8'h10;
    localparam logic [7:0] SHIFT_RES_OFS = 8'h14;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int ENABLE_BIT    = 15;
    localparam int COUNT_LSB     = 8;
    localparam int FULL_BIT      = 7;
    localparam int EMPTY_BIT     = 6;
    localparam int BUSY_BIT      = 5;
    localparam int GO_BIT        = 4;
    localparam int LSB_FIRST_BIT = 3;
    localparam int WIDTH_LSB     = 8;
    localparam int POLY_LENGTH_FIELD_LSB      = 0;
    localparam int FIELD_W       = 5;

    // ***************************************************************
    // reset values and masks
    // ***************************************************************
    localparam logic [31:0] TAPS_RST       = 32'h0000_0000;
    localparam logic [31:0] CRC_RST        = 32'h0000_0000;
    localparam logic [4:0]  FIELD_RST      = 5'h00;
    localparam logic [31:0] TAP_WR_MASK    = 32'hffff_fffe;
    localparam logic [31:0] CONST_TERM     = 32'h0000_0001;
    localparam logic [31:0] LEN_MASK_ALL   = 32'hffff_ffff;
    localparam logic [4:0]  FIELD_MAX      = 5'h1f;

    // ***************************************************************
    // fifo depth per element width
    // ***************************************************************
    localparam logic [4:0] DEPTH_NARROW     = 5'h10;
    localparam logic [4:0] DEPTH_MID        = 5'h08;
    localparam logic [4:0] DEPTH_WIDE       = 5'h04;
    localparam logic [4:0] WIDTH_NARROW_MAX = 5'h07;
    localparam logic [4:0] WIDTH_MID_MAX    = 5'h0f;
    localparam int         FIFO_SLOTS       = 16;

    // ***************************************************************
    // transfer sequencer
    // ***************************************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_XFER  = 3'b010,
        ST_SHIFT = 3'b100
    } xfer_state_e;

endpackage

// file: tb/testbench.sv
// self-checking apb testbench of the programmable crc fifo engine
`timescale 1ns/1ps
`default_nettype none
module testbench
    import crc_fifo_pkg::*;
;
    // ***************************************************************
    // clock, reset, bus and bookkeeping
    // ***************************************************************
    logic              sys_clk   = 1'b0;
    logic              reset     = 1'b1;
    logic              psel      = 1'b0;
    logic              penable   = 1'b0;
    logic              pwrite    = 1'b0;
    logic [ADDR_W-1:0] paddr     = '0;
    logic [31:0]       pwdata    = '0;
    logic [3:0]        pstrb     = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              serr;
    logic [31:0]       r;
    logic [31:0]       ex;
    logic [31:0]       lsbv;
    int                err_count = 0;
    int                checks    = 0;
    int                cyc       = 0;
    logic [4:0]        fw [3]    = '{5'h07, 5'h0f, 5'h1f};
    int                depth [3] = '{16, 8, 4};
    logic [4:0]        tw [5]    = '{5'h07, 5'h0f, 5'h05, 5'h1f, 5'h0b};
    logic [4:0]        tp [5]    = '{5'h0f, 5'h0f, 5'h07, 5'h1f, 5'h0b};
    logic [31:0]       tt [5]    = '{32'h0001_1021, 32'h0000_1021, 32'h0000_0107, 32'h04c1_1db7, 32'h0000_080f};
    logic [31:0]       te [5]    = '{32'h0000_01a5, 32'h0000_c3a5, 32'h0000_00ff, 32'h1234_5678, 32'h0000_fabc};
    logic              tl [5]    = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1};

    always #5 sys_clk = ~sys_clk;

    crc_fifo_engine DUT (
        .sys_clk (sys_clk),
        .reset   (reset),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .pstrb   (pstrb),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr)
    );

    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles; a hang is cut off well beyond
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            close_out();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one transfer; request held until pready is sampled high, then an idle edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no cycle count assumed here: only the bench timeout ends a hung wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        r       = prdata;
        serr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 4'hf);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk(r, e);
    endtask

    // byte, halfword or low-then-high pair, as the element width asks
    task automatic push(input logic [4:0] w, input logic [31:0] e);
        if (w <= 5'h07) xfer(1'b1, DATA_LOW_OFS, e, 4'h1);
        else if (w <= 5'h0f) xfer(1'b1, DATA_LOW_OFS, e, 4'h3);
        else begin
            wr(DATA_LOW_OFS, e);
            wr(DATA_HIGH_OFS, {16'h0, e[31:16]});
        end
    endtask

    // polls the control word until the queue is empty and the engine idle, or until 100 polls have been made
    task automatic wait_idle();
        int n = 0;
        do begin
            xfer(1'b0, CTRL_A_OFS, 32'h0, 4'h0);
            n++;
        end while ((r[12:8] != 5'h00 || r[BUSY_BIT]) && n < 100);
    endtask

    // serial reference: one element, no augmentation, result kept non-reflected
    function automatic logic [31:0] crc_elem(input logic [31:0] c, e, t, input logic [4:0] w, pl, input logic lsb);
        logic [31:0] m;
        logic        d;
        logic        fb;
        m = 32'hffff_ffff >> (5'h1f - pl);
        for (int k = 0; k <= w; k++) begin
            d = lsb ? e[k] : e[w - k];
            fb = c[pl];
            c = ({c[30:0], d} ^ (fb ? (t | 32'h1) : 32'h0)) & m;
        end
        return c;
    endfunction

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        repeat (16) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        rdchk(CTRL_A_OFS, 32'h0000_0040);
        rdchk(CTRL_B_OFS, 32'h0);
        rdchk(POLY_TAP_OFS, 32'h0);
        rdchk(SHIFT_RES_OFS, 32'h0);
        xfer(1'b0, 8'h18, 32'h0, 4'h0);
        chk({31'h0, serr}, 32'h1);
        chk(r, 32'h0);
        wr(CTRL_B_OFS, 32'hffff_ffff);
        rdchk(CTRL_B_OFS, 32'h0000_1f1f);
        wr(POLY_TAP_OFS, 32'hffff_ffff);
        rdchk(POLY_TAP_OFS, 32'hffff_fffe);
        $display("test registers done");
        for (int j = 0; j < 3; j++) begin
            wr(CTRL_B_OFS, {19'h0, fw[j], 8'h00});
            wr(CTRL_A_OFS, 32'h0000_8000);
            if (j == 2) begin
                wr(DATA_LOW_OFS, 32'h1);
                rdchk(CTRL_A_OFS, 32'h0000_8040);
            end
            push(fw[j], 32'h0);
            rdchk(CTRL_A_OFS, 32'h0000_8100);
            for (int k = 0; k < depth[j]; k++) push(fw[j], k);
            rdchk(CTRL_A_OFS, 32'h0000_8080 | (depth[j] << 8));
            rdchk(DATA_LOW_OFS, 32'h0);
            rdchk(DATA_HIGH_OFS, 32'h0);
            // one entry moves out and shifts for width+1 cycles, so this read lands mid-shift
            wr(CTRL_A_OFS, 32'h0000_8010);
            repeat (3) @(posedge sys_clk);
            rdchk(CTRL_A_OFS, 32'h0000_8030 | ((depth[j] - 1) << 8));
            wr(CTRL_A_OFS, 32'h0);
            // the paused element is abandoned by a direct engine load
            wr(SHIFT_RES_OFS, 32'h0);
            rdchk(CTRL_A_OFS, 32'h0000_0040);
        end
        $display("test fifo depths done");
        for (int i = 0; i < 5; i++) begin
            lsbv = {28'h0, tl[i], 3'h0};
            wr(CTRL_B_OFS, {19'h0, tw[i], 3'h0, tp[i]});
            wr(POLY_TAP_OFS, tt[i]);
            // case 1 keeps the running sum across a width change while idle
            if (i != 1) begin
                ex = 32'h5a5a_c3c3 & (32'hffff_ffff >> (5'h1f - tp[i]));
                wr(SHIFT_RES_OFS, ex);
                rdchk(SHIFT_RES_OFS, ex);
            end
            wr(CTRL_A_OFS, 32'h0000_8010 | lsbv);
            push(tw[i], te[i]);
            wr(CTRL_A_OFS, 32'h0000_8000 | lsbv);
            rdchk(CTRL_A_OFS, 32'h0000_8060 | lsbv);
            wr(CTRL_A_OFS, 32'h0000_8010 | lsbv);
            push(tw[i], ~te[i]);
            wait_idle();
            chk(r, 32'h0000_8050 | lsbv);
            ex = crc_elem(ex, te[i], tt[i], tw[i], tp[i], tl[i]);
            ex = crc_elem(ex, ~te[i], tt[i], tw[i], tp[i], tl[i]);
            rdchk(SHIFT_RES_OFS, ex);
        end
        $display("test crc runs done");
        close_out();
    end
endmodule
`default_nettype wire
